// ==== rtl/charge_mode_defines.svh ====
`ifndef CHARGE_MODE_DEFINES_SVH
`define CHARGE_MODE_DEFINES_SVH

// register byte addresses
`define ADDR_CTRL          8'h00
`define ADDR_INPUT_CURRENT_LIMIT_SEL          8'h04
`define ADDR_FAST_PERIOD   8'h08
`define ADDR_STATUS        8'h0c
`define ADDR_INT_STATUS    8'h10
`define ADDR_INT_MASK      8'h14

// control register fields and reset value
`define CTRL_EN_BIT        0
`define CTRL_PIN_FN_BIT    1
`define CTRL_FAULT_CLR_BIT 2
`define CTRL_RESET         2'h1

// input current limit codes
`define INPUT_CURRENT_LIMIT_SEL_100MA         3'h0
`define INPUT_CURRENT_LIMIT_SEL_150MA         3'h1
`define INPUT_CURRENT_LIMIT_SEL_300MA         3'h2
`define INPUT_CURRENT_LIMIT_SEL_500MA         3'h3
`define INPUT_CURRENT_LIMIT_SEL_900MA         3'h4
`define INPUT_CURRENT_LIMIT_SEL_1500MA        3'h5
`define INPUT_CURRENT_LIMIT_SEL_MAX_CODE      3'h5
`define INPUT_CURRENT_LIMIT_SEL_RESET         `INPUT_CURRENT_LIMIT_SEL_100MA

// fast charge period in minutes
`define FAST_PERIOD_RESET  8'h78

// charger status codes
`define STAT_OFF           3'h0
`define STAT_TRICKLE       3'h1
`define STAT_FAST_CC       3'h2
`define STAT_FAST_CV       3'h3
`define STAT_WEAK          3'h4
`define STAT_STOPPED       3'h5
`define STAT_FAULT         3'h7

// status register field positions
`define STATUS_LIMIT_BIT   3
`define STATUS_INPUT_CURRENT_LIMIT_SEL_LSB    4
`define STATUS_ACTIVE_BIT  7

// interrupt status bits
`define INT_MODE_BIT       0
`define INT_FAULT_BIT      1
`define INT_LIMIT_BIT      2
`define INT_STOP_BIT       3
`define INT_WIDTH          4

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// timing
`define CLK_FREQ_HZ        25000000
`define SEC_PER_MIN        60
`define TICKS_PER_MIN      (`CLK_FREQ_HZ * `SEC_PER_MIN)
`define TRICKLE_TIMEOUT_MIN 60

`endif

// ==== rtl/charge_mode_pkg.sv ====
package charge_mode_pkg;

    // charge sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_OFF     = 7'b0000001,
        ST_TRICKLE = 7'b0000010,
        ST_WEAK    = 7'b0000100,
        ST_FAST_CC = 7'b0001000,
        ST_FAST_CV = 7'b0010000,
        ST_STOPPED = 7'b0100000,
        ST_FAULT   = 7'b1000000
    } charge_state_t;

    // order of the synchronised comparator inputs
    typedef enum int {
        IN_ABOVE_DEAD   = 0,
        IN_ABOVE_WEAK   = 1,
        IN_AT_TERM      = 2,
        IN_BELOW_END    = 3,
        IN_BELOW_RECH   = 4,
        IN_ISO_BELOW_SP = 5,
        IN_LIMIT_HIT    = 6,
        IN_LIMIT_PIN    = 7
    } sync_index_t;

endpackage : charge_mode_pkg

// ==== rtl/charge_timer.sv ====
`timescale 1ns/1ps
`include "charge_mode_defines.svh"

module charge_timer #(
    parameter int unsigned TICKS_PER_MIN = `TICKS_PER_MIN
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       run,
    input  wire logic [7:0] limit_min,
    // result
    output logic            expired
);

    logic [30:0] tick;
    logic [7:0]  minutes;
    wire         minute_done = (tick == 31'(TICKS_PER_MIN - 1));

    // minute prescaler and minute count, cleared whenever not running
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            tick    <= 31'h0;
            minutes <= 8'h0;
        end else if (minute_done) begin
            tick    <= 31'h0;
            minutes <= (minutes == 8'hff) ? minutes : minutes + 8'h1;
        end else begin
            tick    <= tick + 31'h1;
        end
    end

    // expiry stays high until the run is withdrawn
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            expired <= 1'b0;
        end else if (minutes >= limit_min) begin
            expired <= 1'b1;
        end
    end

endmodule : charge_timer

// ==== rtl/charge_mode_controller.sv ====
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "charge_mode_defines.svh"

// Summary of operation
// - limit resets 100 mA; written value other than 100 mA beats pin
// - default limit plus pin: low 100, high 500
// - limit codes 100,150,300,500,900,1500 mA
// - flag when input limit restricts fast charge
// - below dead threshold: trickle, trickle code
// - trickle: isolation off, regulator at trickle setpoint
// - trickle over 60 minutes: stop, fault code
// - dead to weak threshold: weak charge mode
// - weak mode holds input limit at 100 mA
// - weak: 20 mA trickle branch, residual to battery
// - fast CC: isolation switch regulates system node
// - termination reached: constant voltage, code 011
// - fast period expires before termination: fault
// - expiry in CV: stop, no fault, recharge resumes
// - charge enable low disables all charging
module charge_mode_controller
    import charge_mode_pkg::*;
#(
    parameter int unsigned TICKS_PER_MIN = `TICKS_PER_MIN
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // comparators and pin from the power stage
    input  wire logic        bat_above_dead,
    input  wire logic        bat_above_weak,
    input  wire logic        bat_at_term,
    input  wire logic        chg_below_end,
    input  wire logic        bat_below_recharge,
    input  wire logic        iso_below_setpoint,
    input  wire logic        input_limit_hit,
    input  wire logic        limit_select_pin,
    // power stage controls
    output logic             trickle_branch_en,
    output logic             trickle_weak_level,
    output logic             main_charge_en,
    output logic             iso_switch_on,
    output logic             iso_regulate_en,
    output logic             ldo_trickle_setpoint,
    output logic             cv_regulate_en,
    output logic [2:0]       active_input_current_limit_sel_code,
    // status
    output logic             input_limit_active_flag,
    output logic [2:0]       charger_status,
    output logic             irq
);

    // two-stage synchronisers for every comparator and pin input from the power stage
    wire  [7:0] raw_in = {limit_select_pin, input_limit_hit, iso_below_setpoint, bat_below_recharge,
                          chg_below_end, bat_at_term, bat_above_weak, bat_above_dead};
    logic [7:0] sync_s1;
    logic [7:0] sync_s2;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync_s1[gi] <= 1'b0;
                    sync_s2[gi] <= 1'b0;
                end else begin
                    sync_s1[gi] <= raw_in[gi];
                    sync_s2[gi] <= sync_s1[gi];
                end
            end
        end
    endgenerate

    // named views of the synchronised bits
    wire above_dead = sync_s2[IN_ABOVE_DEAD];
    wire above_weak = sync_s2[IN_ABOVE_WEAK];
    wire at_term    = sync_s2[IN_AT_TERM];
    wire below_rech = sync_s2[IN_BELOW_RECH];
    wire iso_low    = sync_s2[IN_ISO_BELOW_SP];
    wire limit_hit  = sync_s2[IN_LIMIT_HIT];
    wire pin_high   = sync_s2[IN_LIMIT_PIN];

    // register state
    logic [1:0]             ctrl;
    logic [2:0]             input_current_limit_sel;
    logic [7:0]             fast_charge_period;
    logic [`INT_WIDTH-1:0]  int_status;
    logic [`INT_WIDTH-1:0]  int_mask;
    charge_state_t          state;
    charge_state_t          next_state;

    // write channel holding
    logic        aw_full;
    logic        w_full;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;

    wire aw_hs    = s_axi_awvalid && s_axi_awready;
    wire w_hs     = s_axi_wvalid && s_axi_wready;
    wire ar_hs    = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    wire lane0    = wr_strb[0];

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `ADDR_CTRL) || (a == `ADDR_INPUT_CURRENT_LIMIT_SEL) || (a == `ADDR_FAST_PERIOD) ||
                      (a == `ADDR_STATUS) || (a == `ADDR_INT_STATUS) || (a == `ADDR_INT_MASK);
    endfunction : addr_mapped

    wire wr_ctrl   = do_write && lane0 && (wr_addr == `ADDR_CTRL);
    wire wr_input_current_limit_sel   = do_write && lane0 && (wr_addr == `ADDR_INPUT_CURRENT_LIMIT_SEL);
    wire wr_period = do_write && lane0 && (wr_addr == `ADDR_FAST_PERIOD);
    wire wr_mask   = do_write && lane0 && (wr_addr == `ADDR_INT_MASK);
    wire fault_clr = wr_ctrl && wr_data[`CTRL_FAULT_CLR_BIT];
    wire rd_int    = ar_hs && (s_axi_araddr == `ADDR_INT_STATUS);
    wire charge_en = ctrl[`CTRL_EN_BIT];

    // write address and data taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            wr_addr       <= 8'h0;
            wr_data       <= 32'h0;
            wr_strb       <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_full       <= 1'b1;
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_full && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (w_hs) begin
                w_full       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_full && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
            end
        end
    end

    // software registers; unsupported limit codes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl                    <= `CTRL_RESET;
            input_current_limit_sel <= `INPUT_CURRENT_LIMIT_SEL_RESET;
            fast_charge_period      <= `FAST_PERIOD_RESET;
            int_mask                <= '0;
        end else begin
            if (wr_ctrl) ctrl <= wr_data[1:0];
            if (wr_input_current_limit_sel && wr_data[2:0] <= `INPUT_CURRENT_LIMIT_SEL_MAX_CODE) begin
                input_current_limit_sel <= wr_data[2:0];
            end
            if (wr_period) fast_charge_period <= wr_data[7:0];
            if (wr_mask) int_mask <= wr_data[`INT_WIDTH-1:0];
        end
    end

    // effective input limit selection
    wire sel_is_default = (input_current_limit_sel == `INPUT_CURRENT_LIMIT_SEL_RESET);
    wire pin_selects    = sel_is_default && ctrl[`CTRL_PIN_FN_BIT];
    wire [2:0] pin_code = pin_high ? `INPUT_CURRENT_LIMIT_SEL_500MA : `INPUT_CURRENT_LIMIT_SEL_100MA;
    wire [2:0] host_or_pin = pin_selects ? pin_code : input_current_limit_sel;
    wire [2:0] next_input_current_limit_sel = (state == ST_WEAK) ? `INPUT_CURRENT_LIMIT_SEL_100MA : host_or_pin;

    // charge timers
    logic trickle_expired;
    logic fast_expired;
    charge_timer #(.TICKS_PER_MIN(TICKS_PER_MIN)) u_trickle_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (state == ST_TRICKLE),
        .limit_min (8'(`TRICKLE_TIMEOUT_MIN)),
        .expired   (trickle_expired)
    );
    charge_timer #(.TICKS_PER_MIN(TICKS_PER_MIN)) u_fast_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       ((state == ST_FAST_CC) || (state == ST_FAST_CV)),
        .limit_min (fast_charge_period),
        .expired   (fast_expired)
    );

    // entry mode chosen from the battery comparisons
    wire charge_state_t entry_state = !above_dead ? ST_TRICKLE :
                                      !above_weak ? ST_WEAK :
                                      at_term     ? ST_FAST_CV : ST_FAST_CC;

    // mode sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF:     if (charge_en) next_state = entry_state;
            ST_TRICKLE: if (trickle_expired) next_state = ST_FAULT;
                        else if (above_dead) next_state = above_weak ? ST_FAST_CC : ST_WEAK;
            ST_WEAK:    if (above_weak) next_state = ST_FAST_CC;
                        else if (!above_dead) next_state = ST_TRICKLE;
            ST_FAST_CC: if (at_term) next_state = ST_FAST_CV;
                        else if (fast_expired) next_state = ST_FAULT;
            ST_FAST_CV: if (fast_expired) next_state = ST_STOPPED;
            ST_STOPPED: if (below_rech) next_state = ST_FAST_CV;
            ST_FAULT:   if (fault_clr) next_state = ST_OFF;
            default:    next_state = ST_OFF;
        endcase
        if (!charge_en && state != ST_FAULT) next_state = ST_OFF;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state <= ST_OFF;
        else          state <= next_state;
    end

    // status code per mode
    function automatic logic [2:0] status_code(input charge_state_t s);
        unique case (s)
            ST_TRICKLE: status_code = `STAT_TRICKLE;
            ST_WEAK:    status_code = `STAT_WEAK;
            ST_FAST_CC: status_code = `STAT_FAST_CC;
            ST_FAST_CV: status_code = `STAT_FAST_CV;
            ST_STOPPED: status_code = `STAT_STOPPED;
            ST_FAULT:   status_code = `STAT_FAULT;
            default:    status_code = `STAT_OFF;
        endcase
    endfunction : status_code

    wire in_fast       = (state == ST_FAST_CC) || (state == ST_FAST_CV);
    wire next_limit    = in_fast && limit_hit;
    wire [`INT_WIDTH-1:0] events;
    assign events[`INT_MODE_BIT]  = (next_state != state);
    assign events[`INT_FAULT_BIT] = (next_state == ST_FAULT) && (state != ST_FAULT);
    assign events[`INT_LIMIT_BIT] = next_limit && !input_limit_active_flag;
    assign events[`INT_STOP_BIT]  = (next_state == ST_STOPPED) && (state != ST_STOPPED);

    // power stage controls and status, registered from the current mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trickle_branch_en       <= 1'b0;
            trickle_weak_level      <= 1'b0;
            main_charge_en          <= 1'b0;
            iso_switch_on           <= 1'b0;
            iso_regulate_en         <= 1'b0;
            ldo_trickle_setpoint    <= 1'b0;
            cv_regulate_en          <= 1'b0;
            active_input_current_limit_sel_code        <= `INPUT_CURRENT_LIMIT_SEL_RESET;
            input_limit_active_flag <= 1'b0;
            charger_status          <= `STAT_OFF;
        end else begin
            trickle_branch_en       <= (state == ST_TRICKLE) || (state == ST_WEAK);
            trickle_weak_level      <= (state == ST_WEAK);
            main_charge_en          <= (state == ST_WEAK) || in_fast;
            iso_switch_on           <= (state == ST_WEAK) || in_fast;
            iso_regulate_en         <= (state == ST_WEAK) || ((state == ST_FAST_CC) && iso_low);
            ldo_trickle_setpoint    <= (state == ST_TRICKLE);
            cv_regulate_en          <= (state == ST_FAST_CV);
            active_input_current_limit_sel_code        <= next_input_current_limit_sel;
            input_limit_active_flag <= next_limit;
            charger_status          <= status_code(state);
        end
    end

    // sticky events, a read clears them but a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= '0;
            irq        <= 1'b0;
        end else begin
            int_status <= (int_status & ~(rd_int ? int_status : '0)) | events;
            irq        <= |(int_status & int_mask);
        end
    end

    // read data mux
    wire [31:0] status_word = {24'h0, (state != ST_OFF) && (state != ST_FAULT), active_input_current_limit_sel_code,
                               input_limit_active_flag, charger_status};
    wire [31:0] rd_word = (s_axi_araddr == `ADDR_CTRL)        ? {30'h0, ctrl} :
                          (s_axi_araddr == `ADDR_INPUT_CURRENT_LIMIT_SEL)        ? {29'h0, input_current_limit_sel} :
                          (s_axi_araddr == `ADDR_FAST_PERIOD) ? {24'h0, fast_charge_period} :
                          (s_axi_araddr == `ADDR_STATUS)      ? status_word :
                          (s_axi_araddr == `ADDR_INT_STATUS)  ? {28'h0, int_status} :
                          (s_axi_araddr == `ADDR_INT_MASK)    ? {28'h0, int_mask} : 32'h0;

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_disabled2;
        !charge_en ##1 !charge_en;
    endsequence
    sequence s_in_trickle;
        state == ST_TRICKLE;
    endsequence

    weak_limit_hold_a: assert property ((state == ST_WEAK) |=> active_input_current_limit_sel_code == `INPUT_CURRENT_LIMIT_SEL_100MA)
        else $error("weak mode did not hold 100 mA limit");
    pin_limit_sel_a: assert property ((state != ST_WEAK) && pin_selects && pin_high
                                      |=> active_input_current_limit_sel_code == `INPUT_CURRENT_LIMIT_SEL_500MA)
        else $error("pin high did not select 500 mA");
    host_limit_wins_a: assert property ((state != ST_WEAK) && !sel_is_default
                                        |=> active_input_current_limit_sel_code == $past(input_current_limit_sel))
        else $error("written limit not applied");
    trickle_code_a: assert property (s_in_trickle |=> charger_status == `STAT_TRICKLE)
        else $error("trickle status code wrong");
    trickle_iso_a: assert property (s_in_trickle |=> !iso_switch_on && ldo_trickle_setpoint)
        else $error("trickle isolation or setpoint wrong");
    trickle_timeout_a: assert property (s_in_trickle and (trickle_expired && charge_en) |=> state == ST_FAULT ##1
                                        charger_status == `STAT_FAULT)
        else $error("trickle timeout did not fault");
    fast_cc_code_a: assert property ((state == ST_FAST_CC) |=> charger_status == `STAT_FAST_CC)
        else $error("fast cc status code wrong");
    cv_code_a: assert property ((state == ST_FAST_CC) && at_term && charge_en
                                |=> ##1 charger_status == `STAT_FAST_CV)
        else $error("termination did not give cv code");
    cv_expiry_stop_a: assert property ((state == ST_FAST_CV) && fast_expired && charge_en
                                       |=> state == ST_STOPPED)
        else $error("cv expiry did not stop cleanly");
    disable_off_a: assert property (s_disabled2 ##0 (state != ST_FAULT)
                                    |=> !main_charge_en && !trickle_branch_en)
        else $error("charging not disabled");
    fault_held_a: assert property ((state == ST_FAULT) && !fault_clr |=> state == ST_FAULT)
        else $error("fault code not held");

endmodule : charge_mode_controller

// ==== tb/power_stage_model.sv ====
`timescale 1ns/1ps

// battery comparators of the power stage, driven from a coarse battery level
module power_stage_model (
    // battery level 0 dead, 1 weak, 2 fast, 3 at termination
    input  wire logic [1:0] bat_level,
    // comparator results
    output logic            above_dead,
    output logic            above_weak,
    output logic            at_term
);
    // thresholds ordered dead below weak below termination
    assign above_dead = (bat_level >= 2'h1);
    assign above_weak = (bat_level >= 2'h2);
    assign at_term    = (bat_level == 2'h3);
endmodule : power_stage_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "charge_mode_defines.svh"

module tb_top;
    import charge_mode_pkg::*;
    // design ports and bench state
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, en;
    logic        bat_above_dead, bat_above_weak, bat_at_term, chg_below_end, bat_below_recharge;
    logic        iso_below_setpoint, input_limit_hit, limit_select_pin, trickle_branch_en, trickle_weak_level;
    logic        main_charge_en, iso_switch_on, iso_regulate_en, ldo_trickle_setpoint, cv_regulate_en;
    logic        input_limit_active_flag;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lvl, rsp;
    logic [2:0]  active_input_current_limit_sel_code, charger_status;
    int          num_errors, n_checks, cyc;

    // design with a short minute for simulation
    charge_mode_controller #(.TICKS_PER_MIN(10)) i_charge_mode_controller (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bat_above_dead, .bat_above_weak, .bat_at_term, .chg_below_end,
        .bat_below_recharge, .iso_below_setpoint, .input_limit_hit, .limit_select_pin, .trickle_branch_en,
        .trickle_weak_level, .main_charge_en, .iso_switch_on, .iso_regulate_en, .ldo_trickle_setpoint,
        .cv_regulate_en, .active_input_current_limit_sel_code, .input_limit_active_flag, .charger_status, .irq);
    power_stage_model i_power_stage_model (.bat_level(lvl), .above_dead(bat_above_dead),
        .above_weak(bat_above_weak), .at_term(bat_at_term));

    // clock at 25 mhz
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // mode model: status code from battery level and enable
    function automatic logic [2:0] model_status(input int l, input logic e);
        logic [2:0] q[4] = '{`STAT_TRICKLE, `STAT_WEAK, `STAT_FAST_CC, `STAT_FAST_CV};
        return e ? q[l] : `STAT_OFF;
    endfunction : model_status

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    // bus write, low byte given, upper bytes random
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rnd = xs(rnd);
        s_axi_awaddr <= a;
        s_axi_wdata <= {rnd[31:8], d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask : wr

    task automatic rdreg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rdreg

    // set battery level, let the mode settle, compare status with the model
    task automatic go(input logic [1:0] l, input int n);
        lvl <= l;
        repeat (n) @(posedge aclk);
        chk("status", {29'h0, model_status(l, en)}, {29'h0, charger_status});
    endtask : go

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {chg_below_end, bat_below_recharge, iso_below_setpoint, input_limit_hit, limit_select_pin} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl} = '0;
        s_axi_wstrb = 4'hf;
        rnd = 32'h65d0;
        en = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdreg(`ADDR_INPUT_CURRENT_LIMIT_SEL); chk("input_current_limit_sel", `INPUT_CURRENT_LIMIT_SEL_RESET, rd);
        rdreg(`ADDR_FAST_PERIOD); chk("period", `FAST_PERIOD_RESET, rd);
        rdreg(8'h20); chk("resp", `RESP_SLVERR, rsp);
        wr(`ADDR_INT_MASK, 8'h2);
        chk("bresp", `RESP_OKAY, rsp);
        go(0, 8);
        chk("branch", 1, trickle_branch_en);
        chk("ldo", 1, ldo_trickle_setpoint);
        chk("iso", 0, iso_switch_on);
        chk("irq", 0, irq);
        $display("test trickle done");
        lvl <= 2'h0;
        repeat (610) @(posedge aclk);
        chk("status", `STAT_FAULT, charger_status);
        chk("irq", 1, irq);
        rdreg(`ADDR_INT_STATUS); chk("int", 2, rd & 32'h2);
        repeat (3) @(posedge aclk);
        chk("irq", 0, irq);
        chk("status", `STAT_FAULT, charger_status);
        $display("test trickle timeout done");
        wr(`ADDR_CTRL, 8'h5);
        wr(`ADDR_INPUT_CURRENT_LIMIT_SEL, `INPUT_CURRENT_LIMIT_SEL_500MA);
        go(1, 10);
        chk("weak", 1, trickle_weak_level);
        chk("code", `INPUT_CURRENT_LIMIT_SEL_100MA, active_input_current_limit_sel_code);
        go(2, 10);
        chk("code", `INPUT_CURRENT_LIMIT_SEL_500MA, active_input_current_limit_sel_code);
        input_limit_hit <= 1'b1;
        iso_below_setpoint <= 1'b1;
        go(2, 6);
        chk("flag", 1, input_limit_active_flag);
        chk("isoreg", 1, iso_regulate_en);
        for (int c = 1; c <= `INPUT_CURRENT_LIMIT_SEL_MAX_CODE; c++) begin
            wr(`ADDR_INPUT_CURRENT_LIMIT_SEL, 8'(c));
            go(2, 4);
            chk("code", c, active_input_current_limit_sel_code);
        end
        wr(`ADDR_INPUT_CURRENT_LIMIT_SEL, `INPUT_CURRENT_LIMIT_SEL_100MA);
        wr(`ADDR_CTRL, 8'h3);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            limit_select_pin <= rnd[0];
            go(2, 6);
            chk("code", rnd[0] ? `INPUT_CURRENT_LIMIT_SEL_500MA : `INPUT_CURRENT_LIMIT_SEL_100MA, active_input_current_limit_sel_code);
        end
        go(3, 6);
        chk("cv", 1, cv_regulate_en);
        $display("test modes done");
        wr(`ADDR_CTRL, 8'h0);
        en = 1'b0;
        go(3, 6);
        chk("main", 0, main_charge_en);
        wr(`ADDR_FAST_PERIOD, 8'h2);
        wr(`ADDR_CTRL, 8'h1);
        en = 1'b1;
        go(3, 10);
        repeat (30) @(posedge aclk);
        chk("status", `STAT_STOPPED, charger_status);
        bat_below_recharge <= 1'b1;
        go(3, 5);
        bat_below_recharge <= 1'b0;
        wr(`ADDR_CTRL, 8'h0);
        lvl <= 2'h2;
        wr(`ADDR_CTRL, 8'h1);
        go(2, 6);
        repeat (30) @(posedge aclk);
        chk("status", `STAT_FAULT, charger_status);
        $display("test fast timer done");
        report_and_stop();
    end
endmodule : tb_top
